// ### logic/ebm_block.sv
// Contract
// - single and true dual port offer 8192x1, 4096x2, 2048x4, 1024x9
// - pseudo dual port and fifo also offer 512x18
// - each port of a multi-port mode has its own data width
// - bits laid out linearly, word 0 lsb first, per port width
// - write data and addresses registered on the port clock
// - optional output register after array read data
// - contents preloaded at configuration, visible when operation starts
// - preloaded with writes disabled the block is a read-only memory
// - fifo pointers and flags kept in dedicated internal logic
// - block configurable as ram, rom or fifo
`timescale 1ns/1ns
`default_nettype none
module ebm_block #(
  parameter ebm_pkg::ebm_mode_e MODE = ebm_pkg::EBM_TRUE_DUAL,
  parameter int A_WIDTH = 9,
  parameter int B_WIDTH = 9,
  parameter bit OUT_REG = 1'b0,
  parameter logic [17:0] INIT_FILL = ebm_pkg::EBM_INIT_RST
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic a_ce,
  input wire logic a_we,
  input wire logic [12:0] a_addr,
  input wire logic [17:0] a_wdata,
  output logic [17:0] a_rdata,
  input wire logic b_ce,
  input wire logic b_we,
  input wire logic [12:0] b_addr,
  input wire logic [17:0] b_wdata,
  output logic [17:0] b_rdata,
  output logic fifo_empty,
  output logic fifo_full
);
  // organisations are fixed at build time, widths per port
  localparam int A_DEPTH = ebm_pkg::ebm_depth(A_WIDTH, MODE);
  localparam int B_DEPTH = ebm_pkg::ebm_depth(B_WIDTH, MODE);
  localparam int CAP = A_DEPTH * A_WIDTH;
  localparam bit IS_FIFO = (MODE == ebm_pkg::EBM_FIFO);
  localparam bit IS_ROM = (MODE == ebm_pkg::EBM_ROM);
  localparam bit B_WRITES = (MODE == ebm_pkg::EBM_TRUE_DUAL);
  localparam logic [13:0] AW = 14'(A_WIDTH);
  localparam logic [13:0] BW = 14'(B_WIDTH);
  localparam logic [13:0] CAPW = 14'(CAP);

  typedef struct packed {
    logic a_ce;
    logic a_we;
    logic [12:0] a_addr;
    logic [17:0] a_wdata;
    logic b_ce;
    logic b_we;
    logic [12:0] b_addr;
    logic [17:0] b_wdata;
    logic [17:0] a_rd;
    logic [17:0] b_rd;
    logic [17:0] a_out;
    logic [17:0] b_out;
    logic [13:0] wptr;
    logic [13:0] rptr;
    logic [13:0] cnt;
    logic empty;
    logic full;
  } ebm_state_s;

  localparam int EBM_BITS_L = ebm_pkg::EBM_BITS;
  typedef logic ebm_mem_t [EBM_BITS_L];

  // preload; with no write path this is the whole content of a rom
  function automatic ebm_mem_t ebm_preload();
    ebm_mem_t m;
    for (int i = 0; i < EBM_BITS_L; i++) begin
      m[i] = INIT_FILL[i % ebm_pkg::EBM_DW];
    end
    return m;
  endfunction : ebm_preload

  ebm_state_s s;
  ebm_state_s next_s;
  // given at time zero so the clocked write stays the only process on it
  ebm_mem_t mem = ebm_preload();

  logic [13:0] a_base;
  logic [13:0] b_base;
  logic wr_a;
  logic wr_b;
  logic push;
  logic pop;
  logic [17:0] a_arr;
  logic [17:0] b_arr;

  // bit index of bit i of a word; wraps so any base stays in the array
  function automatic logic [13:0] ebm_idx(input logic [13:0] base,
                                          input int i, input int modulus);
    return 14'((int'(base) + i) % modulus);
  endfunction : ebm_idx

  always_comb begin
    // word n of a port starts at bit n times that port width
    a_base = 14'((int'(s.a_addr) % A_DEPTH) * A_WIDTH);
    b_base = 14'((int'(s.b_addr) % B_DEPTH) * B_WIDTH);
    push = IS_FIFO && s.a_ce && s.a_we && !s.full;
    pop = IS_FIFO && s.b_ce && !s.empty;
    wr_a = !IS_ROM && !IS_FIFO && s.a_ce && s.a_we;
    wr_b = B_WRITES && s.b_ce && s.b_we;
    if (IS_FIFO) begin
      a_base = s.wptr;
      b_base = s.rptr;
    end
    a_arr = '0;
    b_arr = '0;
    for (int i = 0; i < ebm_pkg::EBM_DW; i++) begin
      if (i < A_WIDTH) begin
        a_arr[i] = mem[ebm_idx(a_base, i, IS_FIFO ? CAP : EBM_BITS_L)];
      end
      if (i < B_WIDTH) begin
        b_arr[i] = mem[ebm_idx(b_base, i, IS_FIFO ? CAP : EBM_BITS_L)];
      end
    end
  end

  // array writes come only from the registered copies of the port inputs
  always_ff @(posedge mclk) begin
    for (int i = 0; i < ebm_pkg::EBM_DW; i++) begin
      if (wr_b && i < B_WIDTH) begin
        mem[ebm_idx(b_base, i, EBM_BITS_L)] <= s.b_wdata[i];
      end
      // port a is written after port b for the same i, so it wins a same-bit collision unless the bit sits higher in port b's word
      if ((wr_a || push) && i < A_WIDTH) begin
        mem[ebm_idx(a_base, i, IS_FIFO ? CAP : EBM_BITS_L)] <= s.a_wdata[i];
      end
    end
  end

  always_comb begin
    logic [13:0] nw;
    logic [13:0] nr;
    nw = '0;
    nr = '0;
    next_s = s;
    next_s.a_ce = a_ce;
    next_s.a_we = a_we;
    next_s.a_addr = a_addr;
    next_s.a_wdata = a_wdata;
    next_s.b_ce = b_ce;
    next_s.b_we = b_we;
    next_s.b_addr = b_addr;
    next_s.b_wdata = b_wdata;
    // a read is a port a or port b enable without write, or any port b enable if b cannot write; the fifo pops on port b
    if (!IS_FIFO && s.a_ce && !s.a_we) begin
      next_s.a_rd = a_arr;
    end
    if ((!IS_FIFO && s.b_ce && (!s.b_we || !B_WRITES)) || pop) begin
      next_s.b_rd = b_arr;
    end
    if (OUT_REG) begin
      next_s.a_out = s.a_rd;
      next_s.b_out = s.b_rd;
    end else begin
      next_s.a_out = next_s.a_rd;
      next_s.b_out = next_s.b_rd;
    end
    if (IS_FIFO) begin
      // pointers count bits, so unequal port widths share one capacity
      nw = s.wptr + AW;
      nr = s.rptr + BW;
      if (push) begin
        next_s.wptr = (nw >= CAPW) ? nw - CAPW : nw;
      end
      if (pop) begin
        next_s.rptr = (nr >= CAPW) ? nr - CAPW : nr;
      end
      next_s.cnt = s.cnt + (push ? AW : 14'h0000) - (pop ? BW : 14'h0000);
      next_s.empty = next_s.cnt < BW;
      next_s.full = next_s.cnt > CAPW - AW;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.empty <= IS_FIFO;
    end else begin
      s <= next_s;
    end
  end

  assign a_rdata = s.a_out;
  assign b_rdata = s.b_out;
  assign fifo_empty = s.empty;
  assign fifo_full = s.full;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence a_idle3;
    (!a_ce)[*3];
  endsequence
  sequence b_pop_empty;
    fifo_empty && s.b_ce;
  endsequence

  a_port_inreg: assert property (a_ce ##1 1'b1 |-> s.a_ce &&
    s.a_addr == $past(a_addr)) else $error("port a input not registered");
  a_rdata_hold: assert property (a_idle3 |=> ##1 $stable(a_rdata))
    else $error("port a read data moved without a read");
  a_outreg_lag: assert property (OUT_REG |-> ##1 a_rdata == $past(s.a_rd))
    else $error("output register not one stage behind");
  a_rom_frozen: assert property (IS_ROM |-> !wr_a && !wr_b)
    else $error("rom written");
  a_pop_blocked: assert property (b_pop_empty |=> $stable(s.rptr))
    else $error("read pointer moved while empty");
  a_push_blocked: assert property (fifo_full && s.a_ce && s.a_we
    |=> $stable(s.wptr)) else $error("write pointer moved while full");
  a_count_bound: assert property (s.cnt <= CAPW)
    else $error("fifo count above capacity");
  a_flags_apart: assert property (IS_FIFO |-> !(fifo_empty && fifo_full))
    else $error("fifo empty and full together");
  a_push_count: assert property (push && !pop |=> s.cnt ==
    $past(s.cnt) + AW) else $error("fifo count missed a write");
  a_depth_legal: assert property (A_DEPTH != 0 && B_DEPTH != 0)
    else $error("organisation not offered in this mode");
endmodule : ebm_block
`default_nettype wire

// ### logic/ebm_pkg.sv
`default_nettype none
package ebm_pkg;
  // configuration chosen when the block is built
  typedef enum logic [2:0] {
    EBM_SINGLE = 3'h0,
    EBM_TRUE_DUAL = 3'h1,
    EBM_PSEUDO_DUAL = 3'h2,
    EBM_FIFO = 3'h3,
    EBM_ROM = 3'h4
  } ebm_mode_e;

  localparam int EBM_BITS = 9216;
  localparam int EBM_AW = 13;
  localparam int EBM_DW = 18;
  localparam int EBM_BW = 14;
  localparam int EBM_D1 = 8192;
  localparam int EBM_D2 = 4096;
  localparam int EBM_D4 = 2048;
  localparam int EBM_D9 = 1024;
  localparam int EBM_D18 = 512;
  localparam logic [17:0] EBM_INIT_RST = 18'h00000;

  // words for a width; 0 marks an organisation the mode does not offer
  function automatic int ebm_depth(input int w, input ebm_mode_e m);
    int d;
    d = 0;
    case (w)
      1: d = EBM_D1;
      2: d = EBM_D2;
      4: d = EBM_D4;
      9: d = EBM_D9;
      18: d = (m == EBM_PSEUDO_DUAL || m == EBM_FIFO) ? EBM_D18 : 0;
      default: d = 0;
    endcase
    return d;
  endfunction : ebm_depth
endpackage : ebm_pkg
`default_nettype wire

// ### bench/ebm_fabric.sv
`timescale 1ns/1ns
`default_nettype none
module ebm_fabric (
  input wire logic mclk,
  input wire logic req,
  input wire logic we,
  input wire logic [12:0] addr,
  input wire logic [17:0] wdata,
  input wire logic [17:0] rdata,
  output logic ce,
  output logic we_q,
  output logic [12:0] addr_q,
  output logic [17:0] wdata_q,
  output logic [17:0] rd,
  output logic vld
);
  logic [1:0] p;
  // fabric reads one cycle late on purpose: rdata is settled after E1
  always_ff @(posedge mclk) begin
    ce <= req;
    we_q <= we;
    addr_q <= addr;
    wdata_q <= wdata;
    p <= {p[0], ce};
    vld <= p[1];
    if (p[1]) begin
      rd <= rdata;
    end
  end
endmodule : ebm_fabric
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [17:0] FILL = 18'h2B4C7;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic a_ce = 1'b0;
  logic a_we = 1'b0;
  logic [12:0] a_addr = 13'h0000;
  logic [17:0] a_wdata = 18'h00000;
  logic req = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic req_we = 1'b0;
  logic [17:0] req_wdata = 18'h00000;
  logic f_push = 1'b0;
  logic f_pop = 1'b0;
  logic [17:0] a_rdata, b_rdata, rd, f_rdata, rom_rdata, b_wdata;
  logic [12:0] b_addr;
  logic b_ce, b_we, vld, f_empty, f_full;
  logic [40:0] rows [4];
  logic [8:0] rom_prev = 9'h000;
  int f_exp = 0;
  int bad_count = 0;
  int cmp_count = 0;
  initial forever #50 mclk = ~mclk;
  ebm_block #(.MODE(ebm_pkg::EBM_TRUE_DUAL), .A_WIDTH(9), .B_WIDTH(1),
    .OUT_REG(1'b0), .INIT_FILL(FILL)) uut (.mclk(mclk), .nrst(nrst),
    .a_ce(a_ce), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata),
    .a_rdata(a_rdata), .b_ce(b_ce), .b_we(b_we), .b_addr(b_addr),
    .b_wdata(b_wdata), .b_rdata(b_rdata), .fifo_empty(),
    .fifo_full());
  ebm_fabric fab (.mclk(mclk), .req(req), .we(req_we), .addr(req_addr),
    .wdata(req_wdata), .rdata(b_rdata), .ce(b_ce), .we_q(b_we),
    .addr_q(b_addr), .wdata_q(b_wdata), .rd(rd), .vld(vld));
  // shares both ports' stimulus; every write it sees must be dropped
  ebm_block #(.MODE(ebm_pkg::EBM_ROM), .A_WIDTH(9), .B_WIDTH(9),
    .OUT_REG(1'b1), .INIT_FILL(FILL)) uut_rom (.mclk(mclk), .nrst(nrst),
    .a_ce(a_ce), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata),
    .a_rdata(rom_rdata), .b_ce(b_ce), .b_we(b_we), .b_addr(b_addr),
    .b_wdata(b_wdata), .b_rdata(), .fifo_empty(), .fifo_full());
  ebm_block #(.MODE(ebm_pkg::EBM_FIFO), .A_WIDTH(9), .B_WIDTH(9),
    .OUT_REG(1'b0), .INIT_FILL(FILL)) uut_fifo (.mclk(mclk),
    .nrst(nrst), .a_ce(f_push), .a_we(f_push), .a_addr(a_addr),
    .a_wdata(a_wdata), .a_rdata(), .b_ce(f_pop), .b_we(b_we),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(f_rdata),
    .fifo_empty(f_empty), .fifo_full(f_full));
  task automatic check(input string nm, input logic [17:0] seen,
    input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic b_read(input logic [12:0] ad, input logic exp);
    int n;
    @(posedge mclk) #1;
    req = 1'b1;
    req_addr = ad;
    @(posedge mclk) #1;
    req = 1'b0;
    for (n = 0; n < 8 && vld !== 1'b1; n++) @(posedge mclk) #1;
    if (n == 8) begin
      bad_count++;
      complete_run();
    end else begin
      check("b_rdata", rd, {17'h00000, exp});
    end
  endtask : b_read
  task automatic b_write(input logic [12:0] ad, input logic bit_v);
    @(posedge mclk) #1;
    req = 1'b1;
    req_we = 1'b1;
    req_addr = ad;
    req_wdata = {17'h00000, bit_v};
    @(posedge mclk) #1;
    req = 1'b0;
    req_we = 1'b0;
    repeat (2) @(posedge mclk) #1;
  endtask : b_write
  initial begin
    // columns: write, address, write data, ram read, rom read
    rows[0] = {1'b0, 13'h0000, 9'h000, FILL[8:0], FILL[8:0]};
    rows[1] = {1'b0, 13'h0001, 9'h000, FILL[17:9], FILL[17:9]};
    // a write row leaves both outputs showing the last read
    rows[2] = {1'b1, 13'h0002, 9'h1A5, FILL[17:9], FILL[17:9]};
    rows[3] = {1'b0, 13'h0002, 9'h000, 9'h1A5, FILL[8:0]};
    repeat (20) @(posedge mclk);
    #1;
    check("fifo_empty", {17'h00000, f_empty}, 18'h00001);
    nrst = 1'b1;
    foreach (rows[i]) begin
      @(posedge mclk) #1;
      a_ce = 1'b1;
      a_we = rows[i][40];
      a_addr = rows[i][39:27];
      a_wdata = {9'h000, rows[i][26:18]};
      @(posedge mclk) #1;
      a_ce = 1'b0;
      @(posedge mclk) #1;
      check("a_rdata", a_rdata, {9'h000, rows[i][17:9]});
      check("rom_rdata", rom_rdata, {9'h000, rom_prev});
      @(posedge mclk) #1;
      check("rom_rdata", rom_rdata, {9'h000, rows[i][8:0]});
      rom_prev = rows[i][8:0];
    end
    // the narrow port sees the 9-bit word 2 as bits 18 to 26, lsb first
    for (int k = 0; k < 9; k++) b_read(13'(18 + k), rows[3][9 + k]);
    // a one-bit write on port b lands in bit 0 of word 3 of port a
    b_write(13'h001B, ~FILL[9]);
    @(posedge mclk) #1;
    a_ce = 1'b1;
    a_we = 1'b0;
    a_addr = 13'h0003;
    @(posedge mclk) #1;
    a_ce = 1'b0;
    @(posedge mclk) #1;
    check("a_rdata", a_rdata, {9'h000, FILL[17:10], ~FILL[9]});
    for (int i = 0; i < 1024; i++) begin
      f_push = 1'b1;
      a_wdata = 18'(i[8:0]);
      @(posedge mclk) #1;
    end
    f_push = 1'b0;
    repeat (4) @(posedge mclk) #1;
    check("fifo_full", {17'h00000, f_full}, 18'h00001);
    f_push = 1'b1;
    a_wdata = 18'h000AA;
    @(posedge mclk) #1;
    f_push = 1'b0;
    f_pop = 1'b1;
    for (int j = 0; j < 1032; j++) begin
      @(posedge mclk) #1;
      // a popped word shows one edge after the pop is registered
      f_exp = (j == 0) ? 0 : ((j <= 1024) ? (j - 1) % 512 : 511);
      check("f_rdata", f_rdata, 18'(f_exp));
    end
    check("fifo_empty", {17'h00000, f_empty}, 18'h00001);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
